// ---- core/rshift_map.svh ----
// Purpose: Opcodes, count limits and field positions of the right-shift unit
// Assumes: Included by bare name from the package and the design files
// Notes: Definitions only
`ifndef RSHIFT_MAP_SVH
`define RSHIFT_MAP_SVH

// Opcode bytes of the four right shifts
`define OP_ARITH_WORD 8'h0a
`define OP_ARITH_DWORD 8'h0e
`define OP_ARITH_BYTE 8'h1a
`define OP_LOGIC_BYTE 8'h18

// Second byte below this is an immediate count, else a register address
`define COUNT_REG_BASE 8'h10
// Immediate count lives in the low four bits (0..15)
`define IMM_COUNT_MSB 3
// Register-held count honoured over the low five bits (0..31)
`define REG_COUNT_MSB 4
`define COUNT_W 5

// Operand widths and sign positions
`define DATA_W 32
`define BYTE_MSB 7
`define WORD_MSB 15
`define DWORD_MSB 31
`define BYTE_MASK 32'h0000_00ff
`define WORD_MASK 32'h0000_ffff
`define DWORD_MASK 32'hffff_ffff

`endif

// ---- core/rshift_pkg.sv ----
// Purpose: Types and small decode helpers of the right-shift unit
// Assumes: rshift_map.svh holds every number
// Notes: Functions here are shared by the datapath and the sequencer
`include "rshift_map.svh"

package rshift_pkg;

  // Operand size of the instruction
  typedef enum logic [1:0] {sz_byte, sz_word, sz_dword} op_size_t;

  // Sequencer states
  typedef enum logic [1:0] {idle, shifting, finish} seq_state_t;

  // Mask that keeps only the operand's own bits
  function automatic logic [`DATA_W-1:0] size_mask(input op_size_t sz);
    case (sz)
      sz_byte: size_mask = `BYTE_MASK;
      sz_word: size_mask = `WORD_MASK;
      default: size_mask = `DWORD_MASK;
    endcase
  endfunction

  // Most significant bit of the operand at its own width
  function automatic logic sign_of(input op_size_t sz, input logic [`DATA_W-1:0] v);
    case (sz)
      sz_byte: sign_of = v[`BYTE_MSB];
      sz_word: sign_of = v[`WORD_MSB];
      default: sign_of = v[`DWORD_MSB];
    endcase
  endfunction

endpackage

// ---- core/shift_decode.sv ----
// Purpose: Opcode and count decode for the right-shift unit
// Assumes: Count register content is already fetched by the register file
// Notes: Purely combinational, read by the sequencer on the start cycle
`timescale 1ns/100ps
`include "rshift_map.svh"

module shift_decode (
  // Instruction bytes
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] count_byte_i,
  input wire logic [7:0] reg_count_i,
  // Decoded fields
  output logic valid_o,
  output rshift_pkg::op_size_t size_o,
  output logic arith_o,
  output logic [`COUNT_W-1:0] count_o
);
  import rshift_pkg::*;

  // Opcode to size and fill kind
  always_comb begin
    valid_o = 1'b1;
    size_o = sz_word;
    arith_o = 1'b1;
    case (opcode_i)
      `OP_ARITH_WORD: size_o = sz_word;
      `OP_ARITH_DWORD: size_o = sz_dword;
      `OP_ARITH_BYTE: size_o = sz_byte;
      `OP_LOGIC_BYTE: begin
        size_o = sz_byte;
        arith_o = 1'b0;
      end
      default: valid_o = 1'b0;
    endcase
  end

  // Immediate 0..15 or register content 0..31; upper register bits ignored
  always_comb begin
    if (count_byte_i < `COUNT_REG_BASE) begin
      count_o = {1'b0, count_byte_i[`IMM_COUNT_MSB:0]};
    end else begin
      count_o = reg_count_i[`REG_COUNT_MSB:0];
    end
  end

endmodule

// ---- core/shift_step.sv ----
// Purpose: One halving step of the right-shift datapath
// Assumes: Bits above the operand width are zero on entry
// Notes: Sign is taken from the current top bit, which an arithmetic shift never changes
`timescale 1ns/100ps
`include "rshift_map.svh"

module shift_step (
  // Operand and mode
  input wire logic [`DATA_W-1:0] dest_i,
  input rshift_pkg::op_size_t size_i,
  input wire logic arith_i,
  // Halved operand
  output logic [`DATA_W-1:0] next_dest_o
);
  import rshift_pkg::*;

  logic fill;
  logic [`DATA_W-1:0] fill_bits;

  // Signed halving copies the sign, unsigned halving brings in zero
  assign fill = arith_i & sign_of(size_i, dest_i);
  assign fill_bits = fill ? ~(size_mask(size_i) >> 1) : {`DATA_W{1'b0}};
  // Clip to operand width so byte and word results stay clean
  assign next_dest_o = ((dest_i >> 1) | fill_bits) & size_mask(size_i);

endmodule

// ---- core/right_shift_unit.sv ----
// Purpose: Iterative right-shift execution unit (byte, word, double-word)
// Assumes: Decoder gives one start pulse with opcode, count byte, count register content and operand
// Notes: One bit per clock; carry_i is the current carry, kept when the count is zero
//
// Functional notes
// - Opcode 0a shifts a 16-bit operand right arithmetically, count immediate or from a register.
// - Opcode 0e shifts a 32-bit operand right arithmetically, count immediate or from a register.
// - Opcode 1a shifts an 8-bit operand right arithmetically, second byte count, third byte destination.
// - Opcode 18 shifts an 8-bit operand right logically, count immediate or from a register.
// - An immediate count in the second byte covers zero to fifteen.
// - A register count comes from address 10H..0FFH and covers zero to thirty-one.
// - Arithmetic shifts fill vacated top bits with the original top bit.
// - The logical byte shift fills vacated top bits with zero.
// - Carry ends holding the last bit shifted out of the low end.
// - Each step copies bit 0 to carry, halves the operand, then decrements the count until zero.
// - The sticky flag is cleared at the start of every right shift.
// - The sticky flag is set when a one reached carry and another step follows.
// - An arithmetic step is a signed two's-complement halving.
// - A logical byte step is an unsigned halving.
`timescale 1ns/100ps
`include "rshift_map.svh"

module right_shift_unit (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Instruction from the decoder
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] count_byte_i,
  input wire logic [7:0] dest_reg_i,
  // Operands from the register file
  input wire logic [7:0] reg_count_i,
  input wire logic [`DATA_W-1:0] dest_i,
  input wire logic carry_i,
  // Result to the register file
  output logic [`DATA_W-1:0] result_o,
  output logic [7:0] dest_reg_o,
  output logic done_o,
  output logic busy_o,
  output logic bad_op_o,
  // Status word flag updates
  output logic carry_o,
  output logic sticky_flag_o,
  output logic zero_o,
  output logic neg_o
);
  import rshift_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath step

  logic dec_valid;
  op_size_t dec_size;
  logic dec_arith;
  logic [`COUNT_W-1:0] dec_count;
  logic [`DATA_W-1:0] next_dest;

  seq_state_t state;
  op_size_t size;
  logic arith;
  logic [`DATA_W-1:0] dest;
  logic [`COUNT_W-1:0] remain;
  logic carry;
  logic sticky_flag;
  logic from_shift;
  logic done;
  logic bad_op;
  logic zero;
  logic neg;
  logic [7:0] dest_reg;
  logic accept;
  logic busy;

  shift_decode u_decode (
    .opcode_i(opcode_i),
    .count_byte_i(count_byte_i),
    .reg_count_i(reg_count_i),
    .valid_o(dec_valid),
    .size_o(dec_size),
    .arith_o(dec_arith),
    .count_o(dec_count)
  );

  shift_step u_step (
    .dest_i(dest),
    .size_i(size),
    .arith_i(arith),
    .next_dest_o(next_dest)
  );

  // Starts are ignored while an instruction is running
  assign accept = start_i && (state == idle) && dec_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // One step per clock until the count is used up
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= idle;
    end else begin
      case (state)
        idle: begin
          if (accept) begin
            state <= (dec_count == '0) ? finish : shifting;
          end
        end
        shifting: begin
          if (remain == 5'h01) begin
            state <= finish;
          end
        end
        finish: state <= idle;
        default: state <= idle;
      endcase
    end
  end

  // Remaining count, decremented after each halving
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remain <= '0;
    end else if (accept) begin
      remain <= dec_count;
    end else if (state == shifting) begin
      remain <= remain - 5'h01;
    end
  end

  // Busy kept in its own flop so the port needs no decode; tracks state != idle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy <= 1'b0;
    end else begin
      case (state)
        idle: busy <= accept;
        shifting: busy <= 1'b1;
        default: busy <= 1'b0;
      endcase
    end
  end

  // Instruction attributes held for the whole run
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      size <= sz_word;
      arith <= 1'b1;
      dest_reg <= 8'h00;
    end else if (accept) begin
      size <= dec_size;
      arith <= dec_arith;
      dest_reg <= dest_reg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand, carry and sticky

  // Operand trimmed to its width at load, halved each step
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dest <= '0;
    end else if (accept) begin
      dest <= dest_i & size_mask(dec_size);
    end else if (state == shifting) begin
      dest <= next_dest;
    end
  end

  // Carry takes bit 0 before the halving; zero count keeps the old carry
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      carry <= 1'b0;
    end else if (accept) begin
      carry <= carry_i;
    end else if (state == shifting) begin
      carry <= dest[0];
    end
  end

  // Marks that carry now holds a shifted-out bit, not the entry value
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      from_shift <= 1'b0;
    end else if (accept) begin
      from_shift <= 1'b0;
    end else if (state == shifting) begin
      from_shift <= 1'b1;
    end
  end

  // Entry carry must not count, so only shifted-out ones set the flag
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sticky_flag <= 1'b0;
    end else if (accept) begin
      sticky_flag <= 1'b0;
    end else if ((state == shifting) && from_shift && carry) begin
      sticky_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion and flags

  // Zero and sign flags are taken from the final result
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zero <= 1'b0;
      neg <= 1'b0;
    end else if (state == finish) begin
      zero <= (dest == '0);
      neg <= sign_of(size, dest);
    end
  end

  // Done pulses once per instruction; bad opcode pulses on a start with an unknown opcode while idle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done <= 1'b0;
      bad_op <= 1'b0;
    end else begin
      done <= (state == finish);
      bad_op <= start_i && (state == idle) && !dec_valid;
    end
  end

  assign result_o = dest;
  assign dest_reg_o = dest_reg;
  assign done_o = done;
  assign busy_o = busy;
  assign bad_op_o = bad_op;
  assign carry_o = carry;
  assign sticky_flag_o = sticky_flag;
  assign zero_o = zero;
  assign neg_o = neg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_word_decode: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (opcode_i == `OP_ARITH_WORD) |=> (size == sz_word) && arith)
    else $error("word arithmetic opcode decoded wrongly");

  a_dword_decode: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (opcode_i == `OP_ARITH_DWORD) |=> (size == sz_dword) && arith)
    else $error("dword arithmetic opcode decoded wrongly");

  a_byte_decode: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (opcode_i == `OP_ARITH_BYTE) |=> (size == sz_byte) && arith && (dest_reg == $past(dest_reg_i)))
    else $error("byte arithmetic opcode decoded wrongly");

  a_logic_decode: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (opcode_i == `OP_LOGIC_BYTE) |=> (size == sz_byte) && !arith)
    else $error("byte logical opcode decoded wrongly");

  a_imm_count_range: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (count_byte_i < `COUNT_REG_BASE) |=> (remain == {1'b0, $past(count_byte_i[3:0])}))
    else $error("immediate count not taken from second byte");

  a_reg_count_range: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (count_byte_i >= `COUNT_REG_BASE) |=> (remain == $past(reg_count_i[4:0])))
    else $error("register count not honoured");

  a_arith_sign_fill: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) && arith |=> sign_of(size, dest) == $past(sign_of(size, dest)))
    else $error("arithmetic shift lost the sign");

  a_logic_zero_fill: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) && !arith |=> !dest[`BYTE_MSB] && (dest[`DATA_W-1:8] == '0))
    else $error("logical shift did not fill with zero");

  a_carry_last_out: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) && (remain == 5'h01) |=> (carry == $past(dest[0])) && (state == finish) ##1 done_o)
    else $error("carry does not hold the last bit out");

  a_step_order: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) |=> (remain == $past(remain) - 5'h01) && (dest == ($past(next_dest))))
    else $error("step did not halve and decrement");

  a_sticky_cleared: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept |=> !sticky_flag)
    else $error("sticky flag not cleared at start");

  a_sticky_set: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) && from_shift && carry |=> sticky_flag)
    else $error("sticky flag missed a one in carry");

  a_signed_halving: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) && arith && (size == sz_word)
      |=> $signed(dest[15:0]) == ($signed($past(dest[15:0])) >>> 1))
    else $error("word step is not a signed halving");

  a_unsigned_halving: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == shifting) && !arith |=> dest[7:0] == ($past(dest[7:0]) >> 1))
    else $error("byte step is not an unsigned halving");

  a_zero_count_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    accept && (dec_count == '0)
      |=> (carry == $past(carry_i)) && !sticky_flag && (state == finish) ##1 done_o && (carry_o == $past(carry)))
    else $error("zero count changed carry or skipped completion");

endmodule

// ---- tb/decoder_model.sv ----
// Purpose: Decoder and register file model that feeds the right-shift unit
// Assumes: Bench raises issue_i for one cycle per instruction, at a rising edge
// Notes: Idle inputs toggle every cycle so stale values never pass for data
`timescale 1ns/100ps

module decoder_model (
  // Clock
  input wire logic sys_clk_i,
  // Request from the bench
  input wire logic issue_i,
  input wire logic [7:0] op_i,
  input wire logic [7:0] cnt_i,
  input wire logic [7:0] dr_i,
  input wire logic [31:0] val_i,
  input wire logic cin_i,
  // Instruction and operands to the unit
  output logic start_o = 1'b0,
  output logic [7:0] opcode_o = 8'h00,
  output logic [7:0] count_byte_o = 8'h00,
  output logic [7:0] dest_reg_o = 8'h00,
  output logic [7:0] reg_count_o = 8'h00,
  output logic [31:0] dest_o = 32'h0000_0000,
  output logic carry_o = 1'b0
);
  ////////////////////////////////////////////////////////////////////////////
  // Register file holds the inverted address; high bits set for addresses below 20H, unit must ignore them
  always @(posedge sys_clk_i) begin
    start_o <= issue_i;
    if (issue_i) begin
      opcode_o <= op_i;
      count_byte_o <= cnt_i;
      dest_reg_o <= dr_i;
      reg_count_o <= ~cnt_i;
      dest_o <= val_i;
      carry_o <= cin_i;
    end else begin
      opcode_o <= ~opcode_o;
      count_byte_o <= ~count_byte_o;
      dest_reg_o <= ~dest_reg_o;
      reg_count_o <= ~reg_count_o;
      dest_o <= ~dest_o;
      carry_o <= ~carry_o;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the right-shift unit
// Assumes: Decoder model drives every unit input except clock and reset
// Notes: Expected results come from a bit-serial reference loop
`timescale 1ns/100ps
`include "rshift_map.svh"

module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic issue = 1'b0;
  logic [7:0] op = 8'h00;
  logic [7:0] cb = 8'h00;
  logic [7:0] dr = 8'h00;
  logic [31:0] val = 32'h0000_0000;
  logic cin = 1'b0;
  logic start, carry_in;
  logic [7:0] opcode, count_byte, dest_reg, reg_count, dest_reg_o;
  logic [31:0] dest, result_o;
  logic done_o, busy_o, bad_op_o, carry_o, sticky_flag_o, zero_o, neg_o;
  int failures = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  decoder_model model (.sys_clk_i(sys_clk_i), .issue_i(issue), .op_i(op), .cnt_i(cb), .dr_i(dr),
    .val_i(val), .cin_i(cin), .start_o(start), .opcode_o(opcode), .count_byte_o(count_byte),
    .dest_reg_o(dest_reg), .reg_count_o(reg_count), .dest_o(dest), .carry_o(carry_in));

  right_shift_unit uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(start),
    .opcode_i(opcode), .count_byte_i(count_byte), .dest_reg_i(dest_reg), .reg_count_i(reg_count),
    .dest_i(dest), .carry_i(carry_in), .result_o(result_o), .dest_reg_o(dest_reg_o),
    .done_o(done_o), .busy_o(busy_o), .bad_op_o(bad_op_o), .carry_o(carry_o),
    .sticky_flag_o(sticky_flag_o), .zero_o(zero_o), .neg_o(neg_o));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Reference: returns sticky, carry, sign, result
  function automatic logic [34:0] ref_shift(input logic [7:0] opc, input int n, input logic [31:0] v0,
                                            input logic c0);
    int w;
    logic ar, c, st;
    logic [31:0] v;
    w = (opc == `OP_ARITH_DWORD) ? 32 : (opc == `OP_ARITH_WORD) ? 16 : 8;
    ar = (opc != `OP_LOGIC_BYTE);
    v = (w == 32) ? v0 : v0 & ((32'h1 << w) - 32'h1);
    c = c0;
    st = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i > 0 && c) st = 1'b1;
      c = v[0];
      v = (v >> 1) | ((ar && v[w-1]) ? (32'h1 << (w - 1)) : 32'h0);
    end
    return {st, c, v[w-1], v};
  endfunction

  // One instruction; intrude fires a second start while busy
  task automatic run(input logic [7:0] opc, input logic [7:0] cbyte, input logic [31:0] v, input logic c,
                     input bit intrude);
    int n;
    int k;
    logic [34:0] e;
    n = (cbyte < 8'h10) ? int'(cbyte[3:0]) : int'(~cbyte & 8'h1f);
    e = ref_shift(opc, n, v, c);
    @(posedge sys_clk_i);
    issue <= 1'b1;
    op <= opc;
    cb <= cbyte;
    dr <= ~cbyte;
    val <= v;
    cin <= c;
    @(posedge sys_clk_i);
    issue <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("busy_taken", busy_o, 1);
    chk("sticky_start", sticky_flag_o, 0);
    k = 0;
    while (done_o !== 1'b1 && k < 40) begin
      @(posedge sys_clk_i);
      issue <= intrude && k == 1;
      val <= ~v;
      #1;
      k++;
    end
    chk("latency", k, n + 1);
    chk("result", result_o, e[31:0]);
    chk("carry", carry_o, e[33]);
    chk("sticky", sticky_flag_o, e[34]);
    chk("zero", zero_o, e[31:0] == 32'h0);
    chk("neg", neg_o, e[32]);
    chk("dest_reg", dest_reg_o, 8'(~cbyte));
    @(posedge sys_clk_i);
    #1;
    chk("done_pulse", done_o, 0);
    chk("idle_after", busy_o, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_opcodes();
    logic [7:0] ops [4] = '{`OP_ARITH_WORD, `OP_ARITH_DWORD, `OP_ARITH_BYTE, `OP_LOGIC_BYTE};
    foreach (ops[i]) begin
      run(ops[i], 8'h03, 32'h8765_c3a9, 1'b0, 1'b0);
      run(ops[i], 8'h05, 32'h1234_5678, 1'b1, 1'b0);
    end
    $display("test opcodes done");
  endtask

  task automatic t_counts();
    logic [7:0] cbs [7] = '{8'h00, 8'h0f, 8'h10, 8'he0, 8'hff, 8'hf9, 8'h01};
    foreach (cbs[i]) begin
      run(`OP_ARITH_DWORD, cbs[i], 32'h8000_0001, i[0], 1'b0);
    end
    run(`OP_ARITH_WORD, 8'h00, 32'h0000_8001, 1'b1, 1'b0);
    $display("test counts done");
  endtask

  task automatic t_sticky();
    run(`OP_ARITH_WORD, 8'h02, 32'h0000_8001, 1'b0, 1'b0);
    run(`OP_ARITH_WORD, 8'h03, 32'h0000_0004, 1'b1, 1'b0);
    run(`OP_LOGIC_BYTE, 8'h03, 32'h0000_0005, 1'b0, 1'b0);
    run(`OP_ARITH_BYTE, 8'h00, 32'h0000_00ff, 1'b0, 1'b0);
    $display("test sticky done");
  endtask

  task automatic t_refused();
    run(`OP_ARITH_WORD, 8'he0, 32'h0000_f00f, 1'b0, 1'b1);
    @(posedge sys_clk_i);
    issue <= 1'b1;
    op <= 8'h0c;
    @(posedge sys_clk_i);
    issue <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("bad_op", bad_op_o, 1);
    chk("bad_op_idle", busy_o, 0);
    @(posedge sys_clk_i);
    #1;
    chk("bad_op_pulse", bad_op_o, 0);
    chk("bad_op_done", done_o, 0);
    $display("test refused done");
  endtask

  // Reset pulled in the middle of a long shift, then one clean instruction
  task automatic t_reset();
    @(posedge sys_clk_i);
    issue <= 1'b1;
    op <= `OP_ARITH_DWORD;
    cb <= 8'he0;
    val <= 32'hf000_000f;
    cin <= 1'b1;
    @(posedge sys_clk_i);
    issue <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("rst_busy", busy_o, 0);
    chk("rst_result", result_o, 0);
    chk("rst_carry", carry_o, 0);
    chk("rst_sticky", sticky_flag_o, 0);
    chk("rst_done", done_o, 0);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    run(`OP_ARITH_WORD, 8'h02, 32'h0000_8001, 1'b0, 1'b0);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (11) @(posedge sys_clk_i);
    #1;
    chk("reset_result", result_o, 0);
    chk("reset_busy", busy_o, 0);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_opcodes();
    t_counts();
    t_sticky();
    t_refused();
    t_reset();
    conclude();
  end

  // About 24 instructions of at most 40 cycles each
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    failures++;
    conclude();
  end
endmodule
